// *** hw/trl_pkg.sv ***
// constants shared by the temperature readout and limit block
package trl_pkg;
  // register word indices (byte address is four times the index)
  localparam logic [6:0] CFG_ONE_IDX = 7'h00;
  localparam logic [6:0] CFG_THREE_IDX = 7'h07;
  localparam logic [6:0] LOCAL_TEMP_IDX = 7'h1f;
  localparam logic [6:0] PAIR_LOW_IDX = 7'h27;
  localparam logic [6:0] PAIR_HIGH_IDX = 7'h29;
  localparam logic [6:0] REMOTE_ONE_IDX = 7'h30;
  localparam logic [6:0] HIGH_LIM_IDX = 7'h40;
  localparam logic [6:0] LOW_LIM_IDX = 7'h48;
  localparam logic [6:0] STATUS_IDX = 7'h50;
  localparam logic [6:0] MASK_IDX = 7'h51;
  // field positions
  localparam int START_BIT = 0;
  localparam int PAIR_SEL_BIT = 3;
  localparam int REF_SEL_BIT = 2;
  // reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] HIGH_LIM_RESET = 8'h7f;
  localparam logic [7:0] LOW_LIM_RESET = 8'h00;
  // channel order of one monitoring round
  localparam int NUM_CH = 5;
  localparam logic [2:0] CH_REMOTE_ONE = 3'h0;
  localparam logic [2:0] CH_PAIR_TEMP = 3'h1;
  localparam logic [2:0] CH_ANALOG_EIGHT = 3'h2;
  localparam logic [2:0] CH_ANALOG_NINE = 3'h3;
  localparam logic [2:0] CH_LOCAL = 3'h4;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int REMOTE_CONV_NS = 2140000;
  localparam int ANALOG_CONV_NS = 711000;
  localparam int REMOTE_CONV_CYC = (REMOTE_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ANALOG_CONV_CYC = (ANALOG_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AVG_SAMPLES = 16;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_WAIT, SEQ_STORE} trl_seq_type;
endpackage

// *** hw/trl_avg.sv ***
// accumulator that averages a power-of-two number of 8-bit samples
`timescale 1ns/1ps
module trl_avg import trl_pkg::*; #(
  parameter int SAMPLES = AVG_SAMPLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic add,
  input wire logic is_signed,
  input wire logic [7:0] sample,
  output logic [7:0] avg
);
  localparam int SH = $clog2(SAMPLES);
  logic [7+SH:0] acc;

  // a non power of two would need a true divider instead of the shift
  if (SAMPLES < 2 || (1 << SH) != SAMPLES) begin : g_bad_samples
    $error("trl_avg: SAMPLES must be a power of two");
  end

  // sign or zero extension keeps the sum exact; divide is a plain shift
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      acc <= '0;
    end else if (clr) begin
      acc <= '0;
    end else if (add) begin
      acc <= acc + {{SH{is_signed & sample[7]}}, sample}; // see RQ4
    end
  end

  assign avg = acc[7+SH:SH]; // see RQ4
endmodule // trl_avg

// *** hw/trl_readout.sv ***
// temperature readout sequencer, result registers, limits and interrupt
//
// What this block does
// RQ1 - local sensor average lands in the local value register at 0x1f.
// RQ2 - temperature codes are signed eight bit, one degree per step.
// RQ3 - config one bit 3 picks diode channel (0) or analog inputs (1).
// RQ4 - every stored result is the average of 16 conversions.
// RQ5 - each remote conversion is given at least 2.14 ms.
// RQ6 - remote results are stored as eight bit twos complement.
// RQ7 - config three bit 2 picks the 1.82 V (0) or 2.5 V (1) reference.
// RQ8 - voltage channels flag above high limit or below low limit.
// RQ9 - temperature channels flag above hot limit, hysteresis at or below low limit.
// RQ10 - while start bit set, channels run round robin, remote one to local.
// RQ11 - analog mode stores pair at 0x27/0x29; diode mode temperature at 0x29.
// RQ12 - limits checked at each store, signed for temperature, unsigned for voltage.
`timescale 1ns/1ps
module trl_readout import trl_pkg::*; #(
  parameter int REMOTE_CYC = REMOTE_CONV_CYC,
  parameter int ANALOG_CYC = ANALOG_CONV_CYC,
  parameter int SAMPLES = AVG_SAMPLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic adc_start,
  output logic [2:0] adc_chan,
  input wire logic adc_done,
  input wire logic [7:0] adc_data,
  output logic pair_analog,
  output logic ref_high_sel,
  output logic therm_hot,
  output logic irq
);
  // refuse counts that the 24-bit conversion counter or 8-bit sample counter cannot hold
  if (REMOTE_CYC < 1 || ANALOG_CYC < 1 ||
      REMOTE_CYC >= (1 << 24) || ANALOG_CYC >= (1 << 24)) begin : g_bad_conv
    $error("trl_readout: conversion counts out of range");
  end
  if (SAMPLES < 2 || SAMPLES > 256) begin : g_bad_samples
    $error("trl_readout: SAMPLES out of range");
  end

  logic [7:0] cfg_one, cfg_three;
  logic [7:0] local_val, remote_val, pair_low_val, pair_high_val;
  logic [7:0] high_lim [NUM_CH];
  logic [7:0] low_lim [NUM_CH];
  logic [7:0] status, mask;
  logic [NUM_CH-1:0] hot;
  trl_seq_type state;
  logic [2:0] ch;
  logic [7:0] sample_cnt;
  logic [23:0] conv_cnt;
  logic [7:0] avg;
  logic acc_clr, acc_add, bus_wr, keep, hit;
  logic [7:0] next_set;

  // temperature channels carry signed codes, the pair analog inputs do not
  function automatic logic is_temp(input logic [2:0] c);
    return c == CH_REMOTE_ONE || c == CH_PAIR_TEMP || c == CH_LOCAL;
  endfunction

  function automatic logic above(input logic [7:0] v, input logic [7:0] lim, input logic sgn);
    return sgn ? ($signed(v) > $signed(lim)) : (v > lim); // see RQ12
  endfunction

  function automatic logic [23:0] conv_len(input logic [2:0] c);
    return (c == CH_REMOTE_ONE || c == CH_PAIR_TEMP) ? 24'(REMOTE_CYC) : 24'(ANALOG_CYC);
  endfunction

  assign bus_wr = avs_write && !avs_waitrequest;

  // waitrequest drops for exactly one cycle, the cycle after a request appears
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      avs_readdata <= 32'h0;
      if (avs_read && avs_waitrequest) begin
        if (avs_address == CFG_ONE_IDX) avs_readdata <= {24'h0, cfg_one};
        else if (avs_address == CFG_THREE_IDX) avs_readdata <= {24'h0, cfg_three};
        else if (avs_address == LOCAL_TEMP_IDX) avs_readdata <= {24'h0, local_val}; // see RQ1
        else if (avs_address == PAIR_LOW_IDX) avs_readdata <= {24'h0, pair_low_val};
        else if (avs_address == PAIR_HIGH_IDX) avs_readdata <= {24'h0, pair_high_val};
        else if (avs_address == REMOTE_ONE_IDX) avs_readdata <= {24'h0, remote_val};
        else if (avs_address == STATUS_IDX) avs_readdata <= {24'h0, status};
        else if (avs_address == MASK_IDX) avs_readdata <= {24'h0, mask};
        else if (avs_address >= HIGH_LIM_IDX && avs_address < HIGH_LIM_IDX + 7'(NUM_CH))
          avs_readdata <= {24'h0, high_lim[3'(avs_address - HIGH_LIM_IDX)]};
        else if (avs_address >= LOW_LIM_IDX && avs_address < LOW_LIM_IDX + 7'(NUM_CH))
          avs_readdata <= {24'h0, low_lim[3'(avs_address - LOW_LIM_IDX)]};
      end
    end
  end

  // software writable configuration, mask and limits
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_one <= CFG_RESET;
      cfg_three <= CFG_RESET;
      mask <= 8'h00;
      for (int i = 0; i < NUM_CH; i++) begin
        high_lim[i] <= HIGH_LIM_RESET;
        low_lim[i] <= LOW_LIM_RESET;
      end
    end else if (bus_wr) begin
      if (avs_address == CFG_ONE_IDX) cfg_one <= avs_writedata[7:0];
      if (avs_address == CFG_THREE_IDX) cfg_three <= avs_writedata[7:0];
      if (avs_address == MASK_IDX) mask <= avs_writedata[7:0];
      for (int i = 0; i < NUM_CH; i++) begin
        if (avs_address == HIGH_LIM_IDX + 7'(i)) high_lim[i] <= avs_writedata[7:0];
        if (avs_address == LOW_LIM_IDX + 7'(i)) low_lim[i] <= avs_writedata[7:0];
      end
    end
  end

  assign pair_analog = cfg_one[PAIR_SEL_BIT]; // see RQ3
  assign ref_high_sel = cfg_three[REF_SEL_BIT]; // see RQ7

  // the pair is converted both ways every round; mode decides what is kept
  always_comb begin
    keep = 1'b1;
    if (ch == CH_PAIR_TEMP) keep = !cfg_one[PAIR_SEL_BIT]; // see RQ11
    if (ch == CH_ANALOG_EIGHT || ch == CH_ANALOG_NINE) keep = cfg_one[PAIR_SEL_BIT]; // see RQ11
  end

  // conversion sequencer: SAMPLES conversions per channel, then store
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= SEQ_IDLE;
      ch <= CH_REMOTE_ONE;
      sample_cnt <= 8'h00;
      conv_cnt <= 24'h0;
      adc_start <= 1'b0;
      adc_chan <= CH_REMOTE_ONE;
    end else begin
      adc_start <= 1'b0;
      case (state)
        SEQ_IDLE: begin
          ch <= CH_REMOTE_ONE; // see RQ10
          sample_cnt <= 8'h00;
          if (cfg_one[START_BIT]) state <= SEQ_START;
        end
        SEQ_START: begin
          adc_start <= 1'b1;
          adc_chan <= ch;
          conv_cnt <= conv_len(ch) - 24'h1; // see RQ5
          state <= SEQ_WAIT;
        end
        SEQ_WAIT: begin
          // a done strobe before the minimum time is ignored, not latched
          if (conv_cnt != 24'h0) begin
            conv_cnt <= conv_cnt - 24'h1;
          end else if (adc_done) begin
            if (sample_cnt == 8'(SAMPLES - 1)) begin
              sample_cnt <= 8'h00;
              state <= SEQ_STORE; // see RQ4
            end else begin
              sample_cnt <= sample_cnt + 8'h01;
              state <= SEQ_START;
            end
          end
        end
        SEQ_STORE: begin
          ch <= (ch == CH_LOCAL) ? CH_REMOTE_ONE : ch + 3'h1; // see RQ10
          state <= cfg_one[START_BIT] ? SEQ_START : SEQ_IDLE; // see RQ10
        end
        default: state <= SEQ_IDLE;
      endcase
    end
  end

  // the sum is cleared while idle and as each result is stored, so no stale samples mix
  assign acc_clr = (state == SEQ_STORE) || (state == SEQ_IDLE);
  assign acc_add = (state == SEQ_WAIT) && (conv_cnt == 24'h0) && adc_done;

  trl_avg #(.SAMPLES(SAMPLES)) u_avg (
    .mclk(mclk),
    .rstn(rstn),
    .clr(acc_clr),
    .add(acc_add),
    .is_signed(is_temp(ch)),
    .sample(adc_data),
    .avg(avg)
  );

  // result registers; diode mode leaves the 0x27 register untouched
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      local_val <= 8'h00;
      remote_val <= 8'h00;
      pair_low_val <= 8'h00;
      pair_high_val <= 8'h00;
    end else if (state == SEQ_STORE && keep) begin
      case (ch)
        CH_REMOTE_ONE: remote_val <= avg; // see RQ6
        CH_PAIR_TEMP: pair_high_val <= avg; // see RQ11
        CH_ANALOG_EIGHT: pair_low_val <= avg; // see RQ11
        CH_ANALOG_NINE: pair_high_val <= avg; // see RQ11
        CH_LOCAL: local_val <= avg; // see RQ1
        default: local_val <= local_val;
      endcase
    end
  end

  // limit check on the value being stored
  always_comb begin
    next_set = 8'h00;
    hit = 1'b0;
    if (is_temp(ch)) hit = above(avg, high_lim[ch], 1'b1); // see RQ9
    else hit = above(avg, high_lim[ch], 1'b0) || (avg < low_lim[ch]); // see RQ8
    if (state == SEQ_STORE && keep && hit) next_set[ch] = 1'b1;
  end

  // sticky status, write one to clear; a new event beats a same-cycle clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status <= 8'h00;
    end else begin
      if (bus_wr && avs_address == STATUS_IDX) status <= (status & ~avs_writedata[7:0]) | next_set;
      else status <= status | next_set;
    end
  end

  // hot stays set until the channel cools to its hysteresis limit; the pair flag also clears while analog mode is selected
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hot <= '0;
      therm_hot <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (state == SEQ_STORE && keep && is_temp(ch)) begin
        if (hit) hot[ch] <= 1'b1; // see RQ9
        else if (!above(avg, low_lim[ch], 1'b1)) hot[ch] <= 1'b0; // see RQ9
      end
      // analog mode has no pair diode, so a stale hot flag must not hold the output
      if (cfg_one[PAIR_SEL_BIT]) hot[CH_PAIR_TEMP] <= 1'b0; // see RQ3
      therm_hot <= |hot;
      irq <= |(status & mask);
    end
  end

  // cycles since the last converter start, saturating; an independent check on conv_cnt
  logic [23:0] since_start;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      since_start <= 24'h0;
    end else if (adc_start) begin
      since_start <= 24'h1;
    end else if (since_start != 24'hffffff) begin
      since_start <= since_start + 24'h1;
    end
  end

  // properties below watch the block's own state together with its bus and converter inputs
  sequence store_local_s;
    state == SEQ_STORE && ch == CH_LOCAL;
  endsequence

  sequence last_sample_s;
    state == SEQ_WAIT && conv_cnt == 24'h0 && adc_done && sample_cnt == 8'(SAMPLES - 1);
  endsequence

  local_store_a: assert property (@(posedge mclk) disable iff (!rstn) // see RQ1
    store_local_s |=> local_val == $past(avg)) else $error("local value not stored");
  temp_signed_a: assert property (@(posedge mclk) disable iff (!rstn) // see RQ2
    state == SEQ_STORE && is_temp(ch) && avg[7] && keep |-> !hit || $signed(high_lim[ch]) < 0)
    else $error("negative temperature compared unsigned");
  pair_mode_a: assert property (@(posedge mclk) disable iff (!rstn) // see RQ3
    bus_wr && avs_address == CFG_ONE_IDX |=>
    pair_analog == $past(avs_writedata[PAIR_SEL_BIT])) else $error("pair mode output wrong");
  avg_count_a: assert property (@(posedge mclk) disable iff (!rstn) // see RQ4
    last_sample_s |=> state == SEQ_STORE) else $error("store not after last sample");
  remote_wait_a: assert property (@(posedge mclk) disable iff (!rstn) // see RQ5
    acc_add && (adc_chan == CH_REMOTE_ONE || adc_chan == CH_PAIR_TEMP) |->
    since_start >= 24'(REMOTE_CYC - 1)) else $error("remote wait too short");
  remote_store_a: assert property (@(posedge mclk) disable iff (!rstn) // see RQ6
    state == SEQ_STORE && ch == CH_REMOTE_ONE |=> remote_val == $past(avg))
    else $error("remote value not stored");
  ref_sel_a: assert property (@(posedge mclk) disable iff (!rstn) // see RQ7
    bus_wr && avs_address == CFG_THREE_IDX |=>
    ref_high_sel == $past(avs_writedata[REF_SEL_BIT])) else $error("reference select wrong");
  volt_flag_a: assert property (@(posedge mclk) disable iff (!rstn) // see RQ8
    state == SEQ_STORE && keep && !is_temp(ch) && (avg < low_lim[ch] || avg > high_lim[ch])
    |=> status[$past(ch)]) else $error("voltage limit not flagged");
  hot_flag_a: assert property (@(posedge mclk) disable iff (!rstn) // see RQ9
    state == SEQ_STORE && ch == CH_LOCAL && $signed(avg) > $signed(high_lim[ch]) |=> ##1 therm_hot)
    else $error("hot limit not flagged");
  round_order_a: assert property (@(posedge mclk) disable iff (!rstn) // see RQ10
    store_local_s ##1 cfg_one[0] |-> ch == CH_REMOTE_ONE) else $error("round robin order broken");
  diode_keep_a: assert property (@(posedge mclk) disable iff (!rstn) // see RQ11
    state == SEQ_STORE && !pair_analog && ch == CH_ANALOG_EIGHT |=> $stable(pair_low_val))
    else $error("analog result kept in diode mode");
  irq_level_a: assert property (@(posedge mclk) disable iff (!rstn) // see RQ12
    |(status & mask) |=> irq) else $error("interrupt not raised");
  irq_clear_a: assert property (@(posedge mclk) disable iff (!rstn) // see RQ8
    !(|(status & mask)) |=> !irq) else $error("interrupt stuck high");
endmodule // trl_readout

// *** verif/trl_conv_model.sv ***
// behavioural converter and sensors standing behind the readout block
`timescale 1ns/1ps
module trl_conv_model import trl_pkg::*; (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic adc_start,
  input wire logic [2:0] adc_chan,
  input wire logic [39:0] codes,
  input wire logic slow,
  output logic adc_done,
  output logic [7:0] adc_data
);
  logic [7:0] wait_cnt;
  logic busy;
  logic tog;
  logic [7:0] last;

  // one conversion per start; codes alternate v and v+1 so the mean of 16 is v
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      wait_cnt <= 8'h00;
      tog <= 1'b0;
      last <= 8'h00;
    end else if (adc_start) begin
      busy <= 1'b1;
      wait_cnt <= slow ? 8'h09 : 8'h01; // slow answer outlasts the minimum count
      tog <= ~tog;
      last <= codes[{adc_chan, 3'h0} +: 8] + {7'h00, tog};
    end else if (wait_cnt != 8'h00) begin
      wait_cnt <= wait_cnt - 8'h01;
    end
  end

  // data is only good while done stands; otherwise it shows the inverse
  assign adc_done = busy && (wait_cnt == 8'h00);
  assign adc_data = adc_done ? last : ~last;
endmodule // trl_conv_model

// *** verif/testbench.sv ***
// self-checking bench for the temperature readout and limit block
`timescale 1ns/1ps
module testbench import trl_pkg::*;;
  logic mclk, rstn, avs_read, avs_write, avs_waitrequest, adc_start, adc_done;
  logic pair_analog, ref_high_sel, therm_hot, irq, slow;
  logic [6:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [2:0] adc_chan;
  logic [7:0] adc_data;
  logic [39:0] codes;
  int errors, checks_done;

  // short conversion counts keep each round under a thousand cycles
  trl_readout #(.REMOTE_CYC(4), .ANALOG_CYC(2), .SAMPLES(AVG_SAMPLES)) uut (
    .mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .adc_start(adc_start), .adc_chan(adc_chan),
    .adc_done(adc_done), .adc_data(adc_data), .pair_analog(pair_analog),
    .ref_high_sel(ref_high_sel), .therm_hot(therm_hot), .irq(irq));
  trl_conv_model conv (.mclk(mclk), .rstn(rstn), .adc_start(adc_start), .adc_chan(adc_chan),
    .codes(codes), .slow(slow), .adc_done(adc_done), .adc_data(adc_data));

  // free-running 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic results();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one bus transfer; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h000000, wd};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      results();
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rc(input logic [6:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 8'h00, x);
    chk(x, e);
  endtask

  // start a round, poll until the local result lands, then stop and drain
  task automatic run_round(input logic [7:0] cfg, input logic [7:0] loc);
    logic [31:0] x;
    int n;
    n = 0;
    wr(CFG_ONE_IDX, cfg | 8'h01);
    do begin
      bus(1'b0, LOCAL_TEMP_IDX, 8'h00, x);
      n++;
    end while (x !== {24'h000000, loc} && n < 1000);
    if (x !== {24'h000000, loc}) begin
      errors++;
      results();
    end
    wr(CFG_ONE_IDX, cfg);
    repeat (400) @(posedge mclk);
  endtask

  initial begin
    rstn = 1'b0;
    avs_address = 7'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    codes = {8'h19, 8'h20, 8'h40, 8'he7, 8'h83};
    slow = 1'b0;
    errors = 0;
    checks_done = 0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    // reset values, read-only and unmapped places
    rc(CFG_ONE_IDX, 32'h0);
    rc(CFG_THREE_IDX, 32'h0);
    rc(HIGH_LIM_IDX + 7'h4, 32'h7f);
    rc(LOW_LIM_IDX + 7'h3, 32'h0);
    wr(LOCAL_TEMP_IDX, 8'h55);
    rc(LOCAL_TEMP_IDX, 32'h0);
    wr(7'h7e, 8'hff);
    rc(7'h7e, 32'h0);
    // reference level and pair mode follow their config bits
    wr(CFG_THREE_IDX, 8'h04);
    repeat (2) @(posedge mclk);
    chk({31'h0, ref_high_sel}, 32'h1);
    rc(CFG_THREE_IDX, 32'h04);
    wr(CFG_THREE_IDX, 8'h00);
    repeat (2) @(posedge mclk);
    chk({31'h0, ref_high_sel}, 32'h0);
    wr(CFG_ONE_IDX, 8'h08);
    repeat (2) @(posedge mclk);
    chk({31'h0, pair_analog}, 32'h1);
    // diode mode round with prompt converter and default limits
    run_round(8'h00, 8'h19);
    chk({31'h0, pair_analog}, 32'h0);
    rc(REMOTE_ONE_IDX, 32'h83);
    rc(PAIR_HIGH_IDX, 32'he7);
    rc(PAIR_LOW_IDX, 32'h0);
    rc(STATUS_IDX, 32'h0);
    chk({31'h0, therm_hot}, 32'h0);
    // analog mode round, slow converter; local hot limit below a positive reading
    wr(HIGH_LIM_IDX + 7'h4, 8'hf0);
    wr(HIGH_LIM_IDX + 7'h2, 8'h3f);
    wr(LOW_LIM_IDX + 7'h3, 8'h30);
    codes <= {8'h1b, 8'h20, 8'h40, 8'he7, 8'h83};
    slow <= 1'b1;
    run_round(8'h08, 8'h1b);
    rc(PAIR_LOW_IDX, 32'h40);
    rc(PAIR_HIGH_IDX, 32'h20);
    rc(STATUS_IDX, 32'h1c);
    chk({31'h0, therm_hot}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    // mask one event through, then clear by writing ones
    wr(MASK_IDX, 8'h10);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    wr(STATUS_IDX, 8'h10);
    rc(STATUS_IDX, 32'h0c);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    // cooling below the hysteresis limit releases the hot flag
    wr(HIGH_LIM_IDX + 7'h4, 8'h7f);
    wr(LOW_LIM_IDX + 7'h4, 8'h1e);
    codes <= {8'h1d, 8'h20, 8'h40, 8'he7, 8'h83};
    run_round(8'h00, 8'h1d);
    chk({31'h0, therm_hot}, 32'h0);
    results();
  end
endmodule // testbench
